// *** ccmfb_pkg.sv ***
// Package for the CCM frame block formatter: register map, field layout,
// block constants, state and carrier types.
// Assumes one clock domain and an AXI4-Lite register port with 32-bit data.
package ccmfb_pkg;

    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [5:0] CTRL_OFF   = 6'h00;
    localparam logic [5:0] PLEN_OFF   = 6'h04;
    localparam logic [5:0] STATUS_OFF = 6'h08;
    localparam logic [5:0] FN_LO_OFF  = 6'h0C;
    localparam logic [5:0] FN_HI_OFF  = 6'h10;
    localparam logic [5:0] DROPS_OFF  = 6'h14;

    // ---------------------------------------------------------------
    // Control register fields and reset values
    // ---------------------------------------------------------------
    localparam int          CTRL_MIC_LSB    = 0;
    localparam int          CTRL_KTYPE_LSB  = 4;
    localparam int          CTRL_KID_BIT    = 6;
    localparam int          CTRL_CDU_BIT    = 8;
    localparam int          CTRL_TG_LSB     = 12;
    localparam int          CTRL_NEWKEY_BIT = 31;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_717F;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [15:0] PLEN_RESET      = 16'h0000;
    localparam logic [15:0] DROPS_RESET     = 16'h0000;
    localparam logic [39:0] FN_RESET        = 40'h00_0000_0000;
    localparam logic [39:0] FN_START        = 40'h00_0000_0001;

    // ---------------------------------------------------------------
    // Block layout constants
    // ---------------------------------------------------------------
    localparam logic [7:0]  CTR_FLAGS   = 8'h01;
    localparam logic [1:0]  B0_FLAGS_HI = 2'h1;
    localparam logic [2:0]  B0_FLAGS_LO = 3'h1;
    localparam logic [15:0] ALEN_BASE   = 16'h0015;
    localparam logic [4:0]  LFH_BYTES   = 5'h05;
    localparam logic [4:0]  DMAC_END    = 5'h0B;
    localparam logic [4:0]  SMAC_END    = 5'h11;
    localparam logic [4:0]  TYPE_BYTES  = 5'h02;
    localparam logic [4:0]  BLK_LAST    = 5'h0F;
    localparam int          EPI_BYTE    = 0;
    localparam int          EPI_BIT     = 7;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CCMFB_IDLE, CCMFB_HDR, CCMFB_CTR, CCMFB_B0,
        CCMFB_B1, CCMFB_B2, CCMFB_PAY, CCMFB_POUT
    } ccmfb_state_t;

    typedef enum logic [2:0] {
        CCMFB_K_CTR, CCMFB_K_B0, CCMFB_K_B1, CCMFB_K_B2, CCMFB_K_PAY
    } ccmfb_kind_t;

    typedef enum logic [2:0] {
        CCMFB_P_NONE, CCMFB_P_LFH, CCMFB_P_SECHDR,
        CCMFB_P_CLEAR, CCMFB_P_CIPHER, CCMFB_P_MIC
    } ccmfb_part_t;

    typedef struct packed {
        ccmfb_kind_t  kind;
        logic [15:0]  num;
        logic [127:0] data;
    } ccmfb_blk_t;

    typedef struct packed {
        ccmfb_state_t st;
        logic [31:0]  ctrl;
        logic [15:0]  plen;
        logic [39:0]  fn;
        logic [39:0]  fn_used;
        logic [15:0]  drops;
        logic [4:0]   cnt;
        logic [47:0]  dmac;
        logic [47:0]  smac;
        logic [127:0] b2;
        logic [127:0] pay;
        logic         last_seen;
        logic [15:0]  blk_num;
        ccmfb_blk_t   blk;
        ccmfb_part_t  part;
        logic         aw_held;
        logic         w_held;
        logic [5:0]   waddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic         rx_deliver;
        logic         rx_discard;
    } ccmfb_st_t;

endpackage

// *** ccmfb_formatter.sv ***
// CCM frame block formatter: collects a frame's clear bytes and payload,
// emits counter blocks, the first auth block, B1, B2 and padded payload blocks.
// Assumes an upstream byte builder and a downstream cipher core on aclk.
// Functional notes
// - Counter block is flags byte, 13-byte nonce, 2-byte block number 0..m.
// - Block number is 16-bit binary, LSB at LSB of byte 15.
// - All blocks are laid out MSB first, byte 0 bit 7 leading.
// - Counter flags byte is 0000_0001.
// - Nonce: flags, source MAC, zero byte, 40-bit frame count.
// - Source MAC in Ethernet order, MSB at MSB of nonce byte 1.
// - Nonce byte 0 lands in block byte 1 of counter and first blocks.
// - Nonce flags copy security header byte 0 bits 7:3, low bits zero.
// - Nonce unique per payload, reused unchanged on retransmit or relay.
// - First auth block: flags, nonce, 16-bit payload length in bytes 14-15.
// - First auth flags: 0, 1, integrity length code, then 001.
// - B1: assoc length, two zero bytes, destination MAC, source MAC.
// - B2: header bytes 0-4, extra clear field, then zero padding.
// - Extra field: tags plus length/type, or EtherType for control units.
// - Assoc length is 21 plus tag byte count, or 21 for control units.
// - Encryption-present bit in the B2 header copy is forced to one.
// - Payload bytes fill 16-byte blocks in order from B3 byte 0.
// - Unfilled bytes of the last payload block are zero.
// - Received frame failing the integrity check is discarded.
// - Frame parts: header, security header, clear, cipher text, code.
// - Header, security header and clear part go in clear, authenticated.
// - Control unit clear part is its first 14 bytes through EtherType.
// - Tag chain starts with first auth block then following blocks.
// - Counter blocks 1..m feed cipher text, counter 0 feeds the code.
// - Security header: length code, key type, key id, 40-bit count.
// - Frame count starts at one on a new key, plus one per frame; a non-retransmit frame start in the new key write cycle steps the old count instead.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

module ccmfb_formatter
    import ccmfb_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [5:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [5:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic [7:0]   in_data,
    input  wire logic         in_valid,
    input  wire logic         in_start,
    input  wire logic         in_last,
    input  wire logic         in_retx,
    output logic              in_ready,
    output ccmfb_part_t       in_part,
    output ccmfb_blk_t        blk,
    output logic              blk_valid,
    input  wire logic         blk_ready,
    output logic [47:0]       sec_hdr,
    input  wire logic         rx_chk_valid,
    input  wire logic         rx_chk_pass,
    output logic              rx_deliver,
    output logic              rx_discard
);

    ccmfb_st_t r;
    ccmfb_st_t n;

    // ---------------------------------------------------------------
    // Field views of control
    // ---------------------------------------------------------------
    logic [2:0]  mic_code;
    logic [1:0]  key_type;
    logic        key_identifier;
    logic        control_data_unit;
    logic [2:0]  vlan_tag_byte_count;
    logic [4:0]  hdr_total;
    logic [15:0] alen;
    logic [7:0]  sec_b0;

    // Configuration decode and derived lengths
    always_comb begin
        mic_code            = r.ctrl[CTRL_MIC_LSB +: 3];
        key_type            = r.ctrl[CTRL_KTYPE_LSB +: 2];
        key_identifier      = r.ctrl[CTRL_KID_BIT];
        control_data_unit   = r.ctrl[CTRL_CDU_BIT];
        vlan_tag_byte_count = r.ctrl[CTRL_TG_LSB +: 3];
        // Clear part length from byte 0: header, MACs, then the extra field
        if (control_data_unit) begin
            hdr_total = SMAC_END + TYPE_BYTES;
            alen      = ALEN_BASE;
        end else begin
            hdr_total = SMAC_END + TYPE_BYTES + {2'h0, vlan_tag_byte_count};
            alen      = ALEN_BASE + {13'h0, vlan_tag_byte_count};
        end
        // Security header byte 0, reserved bits zero
        sec_b0 = {1'b0, key_identifier, key_type, 1'b0, mic_code};
    end

    // ---------------------------------------------------------------
    // Block builders
    // ---------------------------------------------------------------
    function automatic logic [103:0] nonce_of(input ccmfb_st_t s, input logic [7:0] hb0);
        // Flags, source MAC, zero byte, frame count, MSB first
        nonce_of = {hb0[7:3], 3'h0, s.smac, 8'h00, s.fn_used};
    endfunction

    function automatic logic [127:0] ctr_of(input ccmfb_st_t s, input logic [7:0] hb0,
                                            input logic [15:0] num);
        ctr_of = {CTR_FLAGS, nonce_of(s, hb0), num};
    endfunction

    function automatic logic [127:0] b0_of(input ccmfb_st_t s, input logic [7:0] hb0,
                                           input logic [2:0] mc);
        b0_of = {1'b0, B0_FLAGS_HI[0], mc, B0_FLAGS_LO, nonce_of(s, hb0), s.plen};
    endfunction

    function automatic logic [127:0] b2_of(input ccmfb_st_t s);
        b2_of = s.b2;
        b2_of[127 - 8 * EPI_BYTE - (7 - EPI_BIT)] = 1'b1;
    endfunction

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_comb begin
        s_axi_awready = !r.aw_held && !r.bvalid;
        s_axi_wready  = !r.w_held && !r.bvalid;
        s_axi_bvalid  = r.bvalid;
        s_axi_bresp   = r.bresp;
        s_axi_arready = !r.rvalid;
        s_axi_rvalid  = r.rvalid;
        s_axi_rdata   = r.rdata;
        s_axi_rresp   = r.rresp;
        in_ready      = (r.st == CCMFB_IDLE) || (r.st == CCMFB_HDR) || (r.st == CCMFB_PAY);
        in_part       = r.part;
        blk           = r.blk;
        blk_valid     = (r.st == CCMFB_CTR) || (r.st == CCMFB_B0) || (r.st == CCMFB_B1)
                     || (r.st == CCMFB_B2) || (r.st == CCMFB_POUT);
        sec_hdr       = {sec_b0, r.fn_used};
        rx_deliver    = r.rx_deliver;
        rx_discard    = r.rx_discard;
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [4:0]  idx;
        logic [31:0] rd;
        logic        hit;
        logic [31:0] merged;
        idx    = 5'h00;
        rd     = 32'h0000_0000;
        hit    = 1'b1;
        merged = r.ctrl;
        n      = r;

        // Receive decision pulses
        n.rx_deliver = rx_chk_valid && rx_chk_pass;
        n.rx_discard = rx_chk_valid && !rx_chk_pass;
        if (rx_chk_valid && !rx_chk_pass) begin
            n.drops = r.drops + 16'h0001;
        end

        // Write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_held = 1'b1;
            n.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_held = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end

        // Register write once both halves are held
        if (r.aw_held && r.w_held && !r.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
                if (r.wstrb[i]) begin
                    merged[8 * i +: 8] = r.wdata[8 * i +: 8];
                end
            end
            unique case (r.waddr)
                CTRL_OFF: begin
                    n.ctrl = merged & CTRL_MASK;
                    if (r.wstrb[3] && r.wdata[CTRL_NEWKEY_BIT]) begin
                        n.fn = FN_START;
                    end
                end
                PLEN_OFF: begin
                    if (r.wstrb[0]) begin
                        n.plen[7:0] = r.wdata[7:0];
                    end
                    if (r.wstrb[1]) begin
                        n.plen[15:8] = r.wdata[15:8];
                    end
                end
                STATUS_OFF, FN_LO_OFF, FN_HI_OFF, DROPS_OFF: begin
                    n.bresp = RESP_OKAY;
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Register read
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            unique case (s_axi_araddr)
                CTRL_OFF:   rd = r.ctrl;
                PLEN_OFF:   rd = {16'h0000, r.plen};
                STATUS_OFF: rd = {r.blk_num, 15'h0000, r.st != CCMFB_IDLE};
                FN_LO_OFF:  rd = r.fn[31:0];
                FN_HI_OFF:  rd = {24'h00_0000, r.fn[39:32]};
                DROPS_OFF:  rd = {16'h0000, r.drops};
                default:    hit = 1'b0;
            endcase
            n.rvalid = 1'b1;
            n.rdata  = rd;
            n.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Frame sequencer
        unique case (r.st)
            CCMFB_IDLE, CCMFB_HDR: begin
                if (in_valid && (r.st == CCMFB_HDR || in_start)) begin
                    idx = (r.st == CCMFB_IDLE) ? 5'h00 : r.cnt;
                    if (r.st == CCMFB_IDLE) begin
                        n.b2      = '0;
                        n.blk_num = 16'h0000;
                        // Reuse last count on retransmit, else take a fresh one
                        if (!in_retx) begin
                            n.fn_used = r.fn;
                            n.fn      = r.fn + FN_START;
                        end
                    end
                    // Header bytes, MACs, then extra clear field
                    if (idx < LFH_BYTES) begin
                        n.b2[127 - 8 * idx -: 8] = in_data;
                        n.part                   = CCMFB_P_LFH;
                    end else if (idx < DMAC_END) begin
                        n.dmac = {r.dmac[39:0], in_data};
                        n.part = CCMFB_P_CLEAR;
                    end else if (idx < SMAC_END) begin
                        n.smac = {r.smac[39:0], in_data};
                        n.part = CCMFB_P_CLEAR;
                    end else begin
                        n.b2[127 - 8 * (idx - SMAC_END + LFH_BYTES) -: 8] = in_data;
                        n.part = CCMFB_P_CLEAR;
                    end
                    n.cnt = idx + 5'h01;
                    n.st  = CCMFB_HDR;
                    if ((idx + 5'h01 == hdr_total) || in_last) begin
                        n.last_seen = in_last;
                        n.st        = CCMFB_CTR;
                        n.blk       = '{CCMFB_K_CTR, 16'h0000, ctr_of(n, sec_b0, 16'h0000)};
                    end
                end
            end
            CCMFB_CTR: begin
                if (blk_ready) begin
                    n.blk_num = r.blk_num + 16'h0001;
                    if (r.blk_num == 16'h0000) begin
                        n.st  = CCMFB_B0;
                        n.blk = '{CCMFB_K_B0, 16'h0000, b0_of(r, sec_b0, mic_code)};
                    end else begin
                        n.st  = CCMFB_POUT;
                        n.blk = '{CCMFB_K_PAY, r.blk_num, r.pay};
                    end
                end
            end
            CCMFB_B0: begin
                if (blk_ready) begin
                    n.st  = CCMFB_B1;
                    n.blk = '{CCMFB_K_B1, 16'h0000, {alen, 16'h0000, r.dmac, r.smac}};
                end
            end
            CCMFB_B1: begin
                if (blk_ready) begin
                    n.st  = CCMFB_B2;
                    n.blk = '{CCMFB_K_B2, 16'h0000, b2_of(r)};
                end
            end
            CCMFB_B2, CCMFB_POUT: begin
                if (blk_ready) begin
                    n.cnt = 5'h00;
                    n.pay = '0;
                    n.st  = r.last_seen ? CCMFB_IDLE : CCMFB_PAY;
                end
            end
            CCMFB_PAY: begin
                if (in_valid) begin
                    n.pay[127 - 8 * r.cnt -: 8] = in_data;
                    n.part                      = CCMFB_P_CIPHER;
                    n.cnt                       = r.cnt + 5'h01;
                    if ((r.cnt == BLK_LAST) || in_last) begin
                        n.last_seen = in_last;
                        n.st        = CCMFB_CTR;
                        n.blk       = '{CCMFB_K_CTR, r.blk_num, ctr_of(r, sec_b0, r.blk_num)};
                    end
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r       <= '0;
            r.st    <= CCMFB_IDLE;
            r.ctrl  <= CTRL_RESET;
            r.plen  <= PLEN_RESET;
            r.fn    <= FN_START;
            r.drops <= DROPS_RESET;
            r.part  <= CCMFB_P_NONE;
        end else begin
            r <= n;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_ctr0_taken;
        blk_valid && blk_ready && blk.kind == CCMFB_K_CTR && blk.num == 16'h0000;
    endsequence
    sequence s_b0_offered;
        blk_valid && blk.kind == CCMFB_K_B0;
    endsequence

    property p_ctr_flags;
        blk_valid && blk.kind == CCMFB_K_CTR |-> blk.data[127:120] == CTR_FLAGS;
    endproperty
    a_ctr_flags: assert property (p_ctr_flags) else $error("counter flags wrong");

    property p_ctr_num;
        blk_valid && blk.kind == CCMFB_K_CTR |-> blk.data[15:0] == blk.num;
    endproperty
    a_ctr_num: assert property (p_ctr_num) else $error("counter number misplaced");

    property p_nonce_layout;
        blk_valid && blk.kind == CCMFB_K_CTR
            |-> blk.data[63:56] == 8'h00 && blk.data[55:16] == r.fn_used && blk.data[114:112] == 3'h0;
    endproperty
    a_nonce_layout: assert property (p_nonce_layout) else $error("nonce layout wrong");

    property p_b0_fields;
        s_b0_offered |-> blk.data[127:126] == 2'h1 && blk.data[122:120] == B0_FLAGS_LO
                      && blk.data[125:123] == mic_code && blk.data[15:0] == r.plen;
    endproperty
    a_b0_fields: assert property (p_b0_fields) else $error("first auth block wrong");

    property p_order;
        s_ctr0_taken |=> s_b0_offered;
    endproperty
    a_order: assert property (p_order) else $error("first auth block not after counter 0");

    property p_b1_alen;
        blk_valid && blk.kind == CCMFB_K_B1
            |-> blk.data[127:112] == alen && blk.data[111:96] == 16'h0000;
    endproperty
    a_b1_alen: assert property (p_b1_alen) else $error("assoc length wrong");

    property p_b2_epi;
        blk_valid && blk.kind == CCMFB_K_B2 |-> blk.data[127 - 8 * EPI_BYTE - (7 - EPI_BIT)];
    endproperty
    a_b2_epi: assert property (p_b2_epi) else $error("encryption indicator not forced");

    property p_hold;
        blk_valid && !blk_ready |=> blk_valid && $stable(blk);
    endproperty
    a_hold: assert property (p_hold) else $error("block changed while stalled");

    property p_discard;
        rx_chk_valid && !rx_chk_pass |=> rx_discard && !rx_deliver;
    endproperty
    a_discard: assert property (p_discard) else $error("failed frame not discarded");

    property p_fn_step;
        r.st == CCMFB_IDLE && in_valid && in_start && !in_retx && !r.bvalid
            |=> r.fn == $past(r.fn) + FN_START && r.fn_used == $past(r.fn);
    endproperty
    a_fn_step: assert property (p_fn_step) else $error("frame count not stepped");

endmodule

// *** ccmfb_core_model.sv ***
// Cipher core stand-in: takes offered blocks and queues them.
// Assumes the formatter's block port on aclk; ready stalls one cycle in three.
`timescale 1ns/1ps

module ccmfb_core_model
    import ccmfb_pkg::*;
(
    input  wire logic       aclk,
    input  wire ccmfb_blk_t blk,
    input  wire logic       blk_valid,
    output logic            blk_ready
);
    ccmfb_blk_t got[$];
    logic [1:0] ph = 2'h0;

    // Queue each block at its handshake edge, rotate the stall phase
    always @(posedge aclk) begin
        if (blk_valid && blk_ready) got.push_back(blk);
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    end
    assign blk_ready = (ph != 2'h0);
endmodule

// *** tb_top.sv ***
// Testbench: registers over AXI4-Lite, a control frame, a resent client frame, block checks.
// Assumes the package and the core model are compiled first.
`timescale 1ns/1ps

module tb_top
    import ccmfb_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic iv = 1'h0, is = 1'h0, il = 1'h0, rxv = 1'h0, rxp = 1'h0, rt = 1'h0;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [7:0]  idat = 8'h00;
    logic        awready, wready, bvalid, arready, rvalid, in_ready, blk_valid, blk_ready, rx_del, rx_dis;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [47:0] sec_hdr;
    ccmfb_part_t in_part;
    ccmfb_blk_t  blk, bg;
    int          fail_count = 0, n_tests = 0, lk = 36;
    localparam logic [103:0] NONCE = {8'h60, 48'h1112_1314_1516, 8'h00, 40'h1};

    ccmfb_formatter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_data(idat),
        .in_valid(iv), .in_start(is), .in_last(il), .in_retx(rt), .in_ready(in_ready),
        .in_part(in_part), .blk(blk), .blk_valid(blk_valid), .blk_ready(blk_ready), .sec_hdr(sec_hdr),
        .rx_chk_valid(rxv), .rx_chk_pass(rxp), .rx_deliver(rx_del), .rx_discard(rx_dis));
    ccmfb_core_model core (.aclk(aclk), .blk(blk), .blk_valid(blk_valid), .blk_ready(blk_ready));

    // Clock generator
    initial forever #20 aclk = ~aclk;

    task stop_test;
        $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(string nm, logic [127:0] e, logic [127:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tmo(int i);
        if (i >= 200) begin
            fail_count++;
            stop_test;
        end
    endtask
    task axw(logic [5:0] a, logic [31:0] d);
        int i;
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        for (i = 0; i < 200 && !(ad && wd); i++) begin
            @(posedge aclk);
            if (awready) begin ad = 1'h1; awv <= 1'h0; end
            if (wready) begin wd = 1'h1; wv <= 1'h0; end
        end
        tmo(i);
        bready <= 1'h1;
        for (i = 0; i < 200; i++) begin @(posedge aclk); if (bvalid) break; end
        tmo(i);
        bready <= 1'h0;
        chk("bresp", RESP_OKAY, bresp);
    endtask
    task axr(logic [5:0] a, logic [31:0] e, logic [1:0] er);
        int i;
        araddr <= a;
        arv <= 1'h1;
        for (i = 0; i < 200; i++) begin @(posedge aclk); if (arready) break; end
        tmo(i);
        arv <= 1'h0;
        rready <= 1'h1;
        for (i = 0; i < 200; i++) begin @(posedge aclk); if (rvalid) break; end
        tmo(i);
        rready <= 1'h0;
        chk("rresp", er, rresp);
        if (er == RESP_OKAY) chk("rdata", e, rdata);
    endtask
    // Frame: header, dest MAC, src MAC, EtherType, 18 payload bytes
    function logic [7:0] fb(int i);
        if (i == 0) return 8'h05;
        if (i < 5) return 8'hA0 + i[7:0];
        if (i < 11) return 8'h1C + i[7:0];
        if (i < 17) return 8'h06 + i[7:0];
        if (i < 19) return (i == 17) ? 8'h88 : 8'hB5;
        return 8'h1D + i[7:0];
    endfunction
    task snd(int k);
        int i;
        idat <= fb(k);
        is <= (k == 0);
        il <= (k == lk);
        iv <= 1'h1;
        for (i = 0; i < 200; i++) begin @(posedge aclk); if (in_ready) break; end
        tmo(i);
    endtask
    task eb(ccmfb_kind_t k, logic [15:0] n, logic [127:0] d);
        int i;
        for (i = 0; i < 200 && core.got.size() == 0; i++) @(posedge aclk);
        tmo(i);
        bg = core.got.pop_front();
        chk("kind", k, bg.kind);
        if (k == CCMFB_K_CTR || k == CCMFB_K_PAY) chk("num", n, bg.num);
        chk("data", d, bg.data);
    endtask
    task rx(logic p);
        rxv <= 1'h1;
        rxp <= p;
        @(posedge aclk);
        rxv <= 1'h0;
        @(posedge aclk);
        chk("deliver", p, rx_del);
        chk("discard", !p, rx_dis);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        axr(CTRL_OFF, CTRL_RESET, RESP_OKAY);
        axr(FN_LO_OFF, 32'h1, RESP_OKAY);
        axr(6'h18, 32'h0, RESP_SLVERR);
        axw(CTRL_OFF, 32'h0000_0163);
        axw(PLEN_OFF, 32'h0000_0012);
        for (int k = 0; k < 37; k++) snd(k);
        iv <= 1'h0;
        eb(CCMFB_K_CTR, 16'h0, {8'h01, NONCE, 16'h0000});
        chk("part", CCMFB_P_CIPHER, in_part);
        eb(CCMFB_K_B0, 16'h0, {8'h59, NONCE, 16'h0012});
        eb(CCMFB_K_B1, 16'h0, {16'h0015, 16'h0, 48'h2122_2324_2526, 48'h1112_1314_1516});
        eb(CCMFB_K_B2, 16'h0, {40'h85_A1A2_A3A4, 16'h88B5, 72'h0});
        eb(CCMFB_K_CTR, 16'h1, {8'h01, NONCE, 16'h0001});
        eb(CCMFB_K_PAY, 16'h1, 128'h3031_3233_3435_3637_3839_3A3B_3C3D_3E3F);
        eb(CCMFB_K_CTR, 16'h2, {8'h01, NONCE, 16'h0002});
        eb(CCMFB_K_PAY, 16'h2, {16'h4041, 112'h0});
        chk("sec_hdr", {8'h63, 40'h1}, sec_hdr);
        axr(FN_LO_OFF, 32'h2, RESP_OKAY);
        // Resent client frame, two tag bytes, ends on its last clear byte
        axw(CTRL_OFF, 32'h0000_2063);
        rt <= 1'h1;
        lk = 20;
        for (int k = 0; k < 21; k++) snd(k);
        iv <= 1'h0;
        rt <= 1'h0;
        eb(CCMFB_K_CTR, 16'h0, {8'h01, NONCE, 16'h0000});
        chk("part", CCMFB_P_CLEAR, in_part);
        eb(CCMFB_K_B0, 16'h0, {8'h59, NONCE, 16'h0012});
        eb(CCMFB_K_B1, 16'h0, {16'h0017, 16'h0, 48'h2122_2324_2526, 48'h1112_1314_1516});
        eb(CCMFB_K_B2, 16'h0, {40'h85_A1A2_A3A4, 32'h88B5_3031, 56'h0});
        axr(FN_LO_OFF, 32'h2, RESP_OKAY);
        // New key restarts the frame count
        axw(CTRL_OFF, 32'h8000_2063);
        axr(FN_LO_OFF, 32'h1, RESP_OKAY);
        axr(CTRL_OFF, 32'h0000_2063, RESP_OKAY);
        rx(1'h0);
        rx(1'h1);
        axr(DROPS_OFF, 32'h1, RESP_OKAY);
        stop_test;
    end
endmodule
